// File: rtl/spc_cmd.sv
// Purpose: command interpreter of the spectrometer
// Assumes: command bytes arrive as a stream, last marks packet end
// Notes: reply streams are byte wide with valid and ready
`timescale 1ns/1ns
`include "spc_regs.svh"
module spc_cmd #(
  parameter int NUM_PLUGS = `SPC_NUM_PLUGS,
  parameter int CFG_DEPTH = `SPC_CFG_DEPTH
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  input wire logic i_high_speed,
  input wire logic i_cmd_valid,
  input wire logic [7:0] i_cmd_data,
  input wire logic i_cmd_last,
  output logic o_cmd_ready,
  output logic o_ep1_valid,
  output logic [7:0] o_ep1_data,
  output logic o_ep1_last,
  input wire logic i_ep1_ready,
  output logic o_ep2_valid,
  output logic [7:0] o_ep2_data,
  output logic o_ep2_last,
  input wire logic i_ep2_ready,
  output logic o_ep7_valid,
  output logic [7:0] o_ep7_data,
  output logic o_ep7_last,
  input wire logic i_ep7_ready,
  output logic o_acq_start,
  input wire logic i_pix_valid,
  input wire logic [15:0] i_pix_data,
  output logic o_pix_ready,
  output logic o_scan_req,
  input wire logic i_scan_done,
  input wire logic [8*NUM_PLUGS-1:0] i_plugin_id,
  input wire logic i_single_strobe_raw,
  input wire logic i_cont_strobe_raw,
  output logic o_lamp_enable,
  output logic o_single_strobe,
  output logic o_cont_strobe,
  output logic o_shutdown_n,
  output logic o_switched_accessory_supply,
  output logic [2:0] o_trigger_mode
);

  // ----------------------------------------
  // functions
  // ----------------------------------------
  function automatic logic [7:0] count_ids(input logic [8*NUM_PLUGS-1:0] ids);
    logic [7:0] n;
    n = '0;
    for (int i = 0; i < NUM_PLUGS; i++) begin
      if (ids[8*i +: 8] != `SPC_ID_NONE) begin
        n = n + 8'h01;
      end
    end
    return n;
  endfunction

  function automatic logic [7:0] pick_id(input logic [8*NUM_PLUGS-1:0] ids, input logic [4:0] k);
    logic [7:0] b;
    b = `SPC_ID_NONE;
    for (int i = 0; i < NUM_PLUGS; i++) begin
      if (k == 5'(i)) begin
        b = ids[8*i +: 8];
      end
    end
    return b;
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  spc_pkg::spc_state_t state;
  logic [4:0] rx_idx;
  logic [7:0] code;
  logic [7:0] arg_lo;
  logic lamp_on;
  logic power_on;
  logic [2:0] trig;
  logic [4:0] tx_k;
  logic rd_wait;
  logic [7:0] slot;
  logic [7:0] plug_count;
  logic [8*NUM_PLUGS-1:0] plug_id;
  logic boot_pend;
  logic [15:0] pix_word;
  logic have_pix;
  logic pix_hi;
  logic [10:0] pix_cnt;
  logic [7:0] mem_rdata;

  // ----------------------------------------
  // receive side decode
  // ----------------------------------------
  logic acc;
  logic exec;
  logic [7:0] code_now;
  logic [7:0] lo_now;
  logic [15:0] val_now;
  logic [4:0] n_bytes;
  logic [4:0] km2;
  logic [4:0] wr_off;
  logic mem_we;
  logic [8:0] mem_waddr;
  logic [8:0] mem_raddr;
  logic ep1_hs;
  logic ep2_hs;
  logic ep7_hs;
  logic [10:0] pkt_mask;
  logic pkt_end;
  logic is_lamp;
  logic is_shut;
  logic is_trig;
  logic is_query;
  logic is_acq;
  logic is_cnt;
  logic is_ids;
  logic is_detect;

  assign o_cmd_ready = (state == spc_pkg::st_rx) && i_ce;
  assign acc = o_cmd_ready && i_cmd_valid;
  assign exec = acc && i_cmd_last;
  assign code_now = (rx_idx == `SPC_IDX_CODE) ? i_cmd_data : code;
  assign lo_now = (rx_idx == `SPC_IDX_LO) ? i_cmd_data : arg_lo;
  assign val_now = {i_cmd_data, arg_lo};
  assign n_bytes = rx_idx + `SPC_LEN_ONE;

  assign is_lamp = (code_now == `SPC_CMD_LAMP) && (n_bytes == `SPC_LEN_VALUE);
  assign is_shut = (code_now == `SPC_CMD_SHUTDOWN) && (n_bytes == `SPC_LEN_VALUE);
  assign is_trig = (code_now == `SPC_CMD_TRIGGER) && (n_bytes == `SPC_LEN_VALUE);
  assign is_query = (code_now == `SPC_CMD_CFG_QUERY) && (n_bytes == `SPC_LEN_QUERY) &&
                    (lo_now < `SPC_CFG_SLOTS);
  assign is_acq = (code_now == `SPC_CMD_ACQUIRE) && (n_bytes == `SPC_LEN_ONE) && power_on;
  assign is_cnt = (code_now == `SPC_CMD_PLUG_COUNT) && (n_bytes == `SPC_LEN_ONE);
  assign is_ids = (code_now == `SPC_CMD_PLUG_IDS) && (n_bytes == `SPC_LEN_ONE);
  assign is_detect = (code_now == `SPC_CMD_PLUG_DETECT) && (n_bytes == `SPC_LEN_ONE);

  assign wr_off = rx_idx - `SPC_CFG_HDR;
  assign mem_we = acc && (code_now == `SPC_CMD_CFG_WRITE) && (rx_idx >= `SPC_CFG_HDR) &&
                  (rx_idx < `SPC_CFG_END) && (arg_lo < `SPC_CFG_WR_SLOTS);
  assign mem_waddr = {arg_lo[4:0], wr_off[3:0]};
  assign km2 = tx_k - `SPC_CFG_HDR;
  assign mem_raddr = {slot[4:0], km2[3:0]};

  spc_cfg_mem #(
    .AW(9),
    .DW(8),
    .DEPTH(CFG_DEPTH)
  ) spc_cfg_mem_i (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_ce(i_ce),
    .i_we(mem_we),
    .i_waddr(mem_waddr),
    .i_wdata(i_cmd_data),
    .i_raddr(mem_raddr),
    .o_rdata(mem_rdata)
  );

  // ----------------------------------------
  // packet collection
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rx_idx <= `SPC_IDX_CODE;
      code <= `SPC_BYTE_RST;
      arg_lo <= `SPC_BYTE_RST;
    end else if (i_ce && acc) begin
      if (rx_idx == `SPC_IDX_CODE) begin
        code <= i_cmd_data;
      end
      if (rx_idx == `SPC_IDX_LO) begin
        arg_lo <= i_cmd_data;
      end
      if (i_cmd_last) begin
        rx_idx <= `SPC_IDX_CODE;
      end else if (rx_idx != `SPC_IDX_MAX) begin
        rx_idx <= rx_idx + `SPC_LEN_ONE;
      end
    end
  end

  // ----------------------------------------
  // lamp, shutdown, trigger
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      lamp_on <= `SPC_LAMP_RST;
    end else if (i_ce && exec && is_lamp) begin
      if (val_now == `SPC_VAL_ZERO) begin
        lamp_on <= 1'b0;
      end else if (val_now == `SPC_VAL_ONE) begin
        lamp_on <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      power_on <= `SPC_POWER_RST;
    end else if (i_ce && exec && is_shut) begin
      power_on <= (val_now != `SPC_VAL_ZERO);
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      trig <= spc_pkg::trig_free;
    end else if (i_ce && exec && is_trig) begin
      if (val_now <= `SPC_TRIG_MAX) begin
        trig <= val_now[2:0];
      end
    end
  end

  assign o_shutdown_n = power_on;
  assign o_switched_accessory_supply = power_on;
  assign o_lamp_enable = lamp_on && power_on;
  assign o_trigger_mode = power_on ? trig : spc_pkg::trig_free;
  assign o_single_strobe = i_single_strobe_raw && o_lamp_enable;
  assign o_cont_strobe = i_cont_strobe_raw && o_lamp_enable;

  // ----------------------------------------
  // plug-in detection
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      boot_pend <= 1'b1;
      o_scan_req <= 1'b0;
    end else if (i_ce) begin
      boot_pend <= 1'b0;
      o_scan_req <= boot_pend || (exec && is_detect);
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      plug_count <= `SPC_BYTE_RST;
      plug_id <= '0;
    end else if (i_ce && i_scan_done) begin
      plug_count <= count_ids(i_plugin_id);
      plug_id <= i_plugin_id;
    end
  end

  // ----------------------------------------
  // reply sequencer
  // ----------------------------------------
  assign ep1_hs = o_ep1_valid && i_ep1_ready;
  assign ep2_hs = o_ep2_valid && i_ep2_ready;
  assign ep7_hs = o_ep7_valid && i_ep7_ready;
  assign pkt_mask = i_high_speed ? `SPC_HS_PKT_MASK : `SPC_FS_PKT_MASK;
  assign pkt_end = (pix_cnt & pkt_mask) == pkt_mask;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state <= spc_pkg::st_rx;
      tx_k <= '0;
      rd_wait <= 1'b1;
      slot <= `SPC_BYTE_RST;
      o_acq_start <= 1'b0;
    end else if (i_ce) begin
      o_acq_start <= 1'b0;
      unique case (state)
        spc_pkg::st_rx: begin
          tx_k <= '0;
          rd_wait <= 1'b1;
          if (exec && is_query) begin
            state <= spc_pkg::st_cfg;
            slot <= lo_now;
          end else if (exec && is_acq) begin
            state <= spc_pkg::st_acq;
            o_acq_start <= 1'b1;
          end else if (exec && is_cnt) begin
            state <= spc_pkg::st_cnt;
          end else if (exec && is_ids) begin
            state <= spc_pkg::st_ids;
          end
        end
        spc_pkg::st_cfg: begin
          rd_wait <= ep1_hs || (rd_wait && 1'b0);
          if (ep1_hs) begin
            tx_k <= tx_k + `SPC_LEN_ONE;
            if (o_ep1_last) begin
              state <= spc_pkg::st_rx;
            end
          end
        end
        spc_pkg::st_cnt: begin
          if (ep7_hs) begin
            state <= spc_pkg::st_rx;
          end
        end
        spc_pkg::st_ids: begin
          if (ep7_hs) begin
            tx_k <= tx_k + `SPC_LEN_ONE;
            if (o_ep7_last) begin
              state <= spc_pkg::st_rx;
            end
          end
        end
        spc_pkg::st_acq: begin
          if (ep2_hs && pix_hi && (pix_cnt == `SPC_PIX_LAST)) begin
            state <= spc_pkg::st_sync;
          end
        end
        spc_pkg::st_sync: begin
          if (ep2_hs) begin
            state <= spc_pkg::st_rx;
          end
        end
        default: begin
          state <= spc_pkg::st_rx;
        end
      endcase
    end
  end

  // ----------------------------------------
  // pixel serializer
  // ----------------------------------------
  assign o_pix_ready = (state == spc_pkg::st_acq) && !have_pix && i_ce;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pix_word <= '0;
      have_pix <= 1'b0;
      pix_hi <= 1'b0;
      pix_cnt <= '0;
    end else if (i_ce) begin
      if (state == spc_pkg::st_rx) begin
        have_pix <= 1'b0;
        pix_hi <= 1'b0;
        pix_cnt <= '0;
      end else if (o_pix_ready && i_pix_valid) begin
        pix_word <= i_pix_data;
        have_pix <= 1'b1;
      end else if (ep2_hs && (state == spc_pkg::st_acq)) begin
        pix_hi <= !pix_hi;
        if (pix_hi) begin
          have_pix <= 1'b0;
          pix_cnt <= pix_cnt + 11'h001;
        end
      end
    end
  end

  // ----------------------------------------
  // reply outputs
  // ----------------------------------------
  // config reply on endpoint one
  assign o_ep1_valid = (state == spc_pkg::st_cfg) && !rd_wait && i_ce;
  assign o_ep1_data = (tx_k == `SPC_IDX_CODE) ? `SPC_CMD_CFG_QUERY :
                      (tx_k == `SPC_IDX_LO) ? slot : mem_rdata;
  assign o_ep1_last = (tx_k == `SPC_CFG_LAST);

  assign o_ep2_valid = ((state == spc_pkg::st_acq && have_pix) || state == spc_pkg::st_sync) && i_ce;
  assign o_ep2_data = (state == spc_pkg::st_sync) ? `SPC_SYNC_BYTE :
                      (pix_hi ? pix_word[15:8] : pix_word[7:0]);
  assign o_ep2_last = (state == spc_pkg::st_sync) || (pix_hi && pkt_end);

  assign o_ep7_valid = ((state == spc_pkg::st_cnt) || (state == spc_pkg::st_ids)) && i_ce;
  assign o_ep7_data = (state == spc_pkg::st_cnt) ? plug_count : pick_id(plug_id, tx_k);
  assign o_ep7_last = (state == spc_pkg::st_cnt) || (tx_k == `SPC_IDS_LAST);

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  sequence seq_last_pixel;
    ep2_hs && (state == spc_pkg::st_acq) && pix_hi && (pix_cnt == `SPC_PIX_LAST);
  endsequence

  sequence seq_sync_out;
    (state == spc_pkg::st_sync) && (o_ep2_data == `SPC_SYNC_BYTE) && o_ep2_last;
  endsequence

  AST_STROBE_GATE: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (o_single_strobe || o_cont_strobe) |-> (lamp_on && power_on))
    else $error("strobe while lamp off");
  AST_SHUT_OUTPUTS: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !power_on |-> (!o_switched_accessory_supply && !o_lamp_enable && !o_shutdown_n &&
                   (o_trigger_mode == spc_pkg::trig_free)))
    else $error("output active in shutdown");
  AST_LAMP_OFF: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (exec && is_lamp && (val_now == `SPC_VAL_ZERO)) |=> !lamp_on)
    else $error("lamp not cleared");
  AST_POWER_UP: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (exec && is_shut && (val_now != `SPC_VAL_ZERO)) |=> power_on)
    else $error("power not restored");
  AST_CFG_LEN: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (ep1_hs && (tx_k == `SPC_IDX_CODE)) |-> (o_ep1_data == `SPC_CMD_CFG_QUERY) ##1 (!ep1_hs || !o_ep1_last) [*8])
    else $error("config reply too short");
  AST_HS_PACKET: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (ep2_hs && o_ep2_last && i_high_speed && (state == spc_pkg::st_acq)) |-> (pix_cnt[7:0] == 8'hFF))
    else $error("high speed packet size wrong");
  AST_SYNC_AFTER: assert property (@(posedge i_clk) disable iff (!i_nrst)
    seq_last_pixel |=> seq_sync_out)
    else $error("sync packet missing");
  AST_TRIG_KEEP: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (exec && is_trig && (val_now > `SPC_TRIG_MAX)) |=> $stable(trig))
    else $error("trigger mode changed by bad value");
  AST_UNKNOWN_IGNORED: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (exec && !(is_lamp || is_shut || is_trig || is_query || is_acq || is_cnt || is_ids))
    |=> (state == spc_pkg::st_rx) && $stable(lamp_on) && $stable(power_on))
    else $error("ignored command had effect");
  AST_IDS_ZERO: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (o_ep7_valid && (state == spc_pkg::st_ids) && o_ep7_last) |-> (o_ep7_data == `SPC_ID_NONE))
    else $error("last id byte not zero");

endmodule

// File: rtl/spc_regs.svh
// Purpose: named constants of the spectrometer command interpreter
// Assumes: included by bare name
// Notes: definitions only
`ifndef SPC_REGS_SVH
`define SPC_REGS_SVH

// ----------------------------------------
// command codes
// ----------------------------------------
`define SPC_CMD_LAMP 8'h03
`define SPC_CMD_SHUTDOWN 8'h04
`define SPC_CMD_CFG_QUERY 8'h05
`define SPC_CMD_CFG_WRITE 8'h06
`define SPC_CMD_ACQUIRE 8'h09
`define SPC_CMD_TRIGGER 8'h0A
`define SPC_CMD_PLUG_COUNT 8'h0B
`define SPC_CMD_PLUG_IDS 8'h0C
`define SPC_CMD_PLUG_DETECT 8'h0D

// ----------------------------------------
// packet lengths and byte indices
// ----------------------------------------
`define SPC_LEN_ONE 5'h01
`define SPC_LEN_QUERY 5'h02
`define SPC_LEN_VALUE 5'h03
`define SPC_LEN_WRITE 5'h12
`define SPC_IDX_CODE 5'h00
`define SPC_IDX_LO 5'h01
`define SPC_IDX_HI 5'h02
`define SPC_IDX_MAX 5'h1F

// ----------------------------------------
// configuration slots
// ----------------------------------------
`define SPC_CFG_HDR 5'h02
`define SPC_CFG_END 5'h12
`define SPC_CFG_LAST 5'h11
`define SPC_CFG_SLOTS 8'h14
`define SPC_CFG_WR_SLOTS 8'h13
`define SPC_CFG_DEPTH 320

// ----------------------------------------
// plug-in accessories
// ----------------------------------------
`define SPC_NUM_PLUGS 6
`define SPC_IDS_LAST 5'h06
`define SPC_ID_NONE 8'h00

// ----------------------------------------
// spectrum stream
// ----------------------------------------
`define SPC_SYNC_BYTE 8'h69
`define SPC_PIX_LAST 11'h7FF
`define SPC_HS_PKT_MASK 11'h0FF
`define SPC_FS_PKT_MASK 11'h01F

// ----------------------------------------
// values and reset states
// ----------------------------------------
`define SPC_VAL_ZERO 16'h0000
`define SPC_VAL_ONE 16'h0001
`define SPC_TRIG_MAX 16'h0004
`define SPC_LAMP_RST 1'b0
`define SPC_POWER_RST 1'b1
`define SPC_BYTE_RST 8'h00

`endif

// File: rtl/spc_pkg.sv
// Purpose: types of the spectrometer command interpreter
// Assumes: nothing
// Notes: used as spc_pkg::name
package spc_pkg;

  typedef enum logic [2:0] {
    st_rx = 3'b000,
    st_cfg = 3'b001,
    st_cnt = 3'b010,
    st_ids = 3'b011,
    st_acq = 3'b100,
    st_sync = 3'b101
  } spc_state_t;

  typedef enum logic [2:0] {
    trig_free = 3'b000,
    trig_soft = 3'b001,
    trig_level = 3'b010,
    trig_sync = 3'b011,
    trig_edge = 3'b100
  } spc_trig_t;

endpackage

// File: rtl/spc_cfg_mem.sv
// Purpose: byte-wide store of the configuration strings
// Assumes: one write and one read port, same clock
// Notes: read data are registered, one cycle latency
`timescale 1ns/1ns
module spc_cfg_mem #(
  parameter int AW = 9,
  parameter int DW = 8,
  parameter int DEPTH = 320
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [DW-1:0] i_wdata,
  input wire logic [AW-1:0] i_raddr,
  output logic [DW-1:0] o_rdata
);

  logic [DW-1:0] mem [DEPTH];

  always_ff @(posedge i_clk) begin
    if (i_ce && i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rdata <= '0;
    end else if (i_ce) begin
      o_rdata <= mem[i_raddr];
    end
  end

endmodule

// File: tb/spc_host_model.sv
// Purpose: host side of the bulk IN endpoints, accepts reply bytes with stalls
// Assumes: one reply stream active at a time
// Notes: ready pattern from a small shift register, changes after the rising edge
`timescale 1ns/1ns
module spc_host_model (
  input wire logic i_clk,
  input wire logic i_nrst,
  output logic o_ep1_ready,
  output logic o_ep2_ready,
  output logic o_ep7_ready
);
  logic [7:0] lfsr;

  // ----------------------------------------
  // stall pattern
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      lfsr <= 8'h5A;
    end else begin
      lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    end
  end

  assign o_ep1_ready = lfsr[0] | lfsr[3];
  assign o_ep2_ready = lfsr[1] | lfsr[6];
  assign o_ep7_ready = lfsr[2];
endmodule

// File: tb/spc_cmd_tb.sv
// Purpose: self-checking bench of the command interpreter
// Assumes: one reply stream at a time, expected bytes queued in order
// Notes: i_ce toggles during the full-speed acquisition
`timescale 1ns/1ns
`include "spc_regs.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin failures++; $display("BAD %0t got %h exp %h", $time, g, e); end end
module spc_cmd_tb;
  logic i_clk = 1'h0;
  logic i_nrst = 1'h0;
  logic hs = 1'h1, cmd_valid = 1'h0, cmd_last = 1'h0, pix_valid = 1'h0, scan_done = 1'h0, ss_raw = 1'h0, cs_raw = 1'h0;
  logic [7:0] cmd_data = 8'h00;
  logic [15:0] pix_data = 16'h0000;
  logic [47:0] plug_ids = 48'h0031000712A0;
  logic r1, r2, r7, v1, v2, v7, l1, l2, l7, acq, pix_ready, cmd_ready, scan_req, lamp, ss, cs, sd_n, sup;
  logic [7:0] d1, d2, d7;
  logic [2:0] trig;
  logic [7:0] pk [18];
  logic [10:0] expq [$];
  logic [10:0] got_b, exp_b;
  logic [31:0] seed = 32'h00000026;
  logic ce = 1'h1, ce_mix = 1'h0;
  int failures = 0, n_checks = 0, acq_n = 0;

  initial begin
    forever #4 i_clk = ~i_clk;
  end

  spc_cmd spc_cmd_i (.i_clk(i_clk), .i_nrst(i_nrst), .i_ce(ce), .i_high_speed(hs), .i_cmd_valid(cmd_valid),
    .i_cmd_data(cmd_data), .i_cmd_last(cmd_last), .o_cmd_ready(cmd_ready), .o_ep1_valid(v1), .o_ep1_data(d1),
    .o_ep1_last(l1), .i_ep1_ready(r1), .o_ep2_valid(v2), .o_ep2_data(d2), .o_ep2_last(l2), .i_ep2_ready(r2),
    .o_ep7_valid(v7), .o_ep7_data(d7), .o_ep7_last(l7), .i_ep7_ready(r7), .o_acq_start(acq),
    .i_pix_valid(pix_valid), .i_pix_data(pix_data), .o_pix_ready(pix_ready), .o_scan_req(scan_req),
    .i_scan_done(scan_done), .i_plugin_id(plug_ids), .i_single_strobe_raw(ss_raw), .i_cont_strobe_raw(cs_raw),
    .o_lamp_enable(lamp), .o_single_strobe(ss), .o_cont_strobe(cs), .o_shutdown_n(sd_n),
    .o_switched_accessory_supply(sup), .o_trigger_mode(trig));

  spc_host_model spc_host_model_i (.i_clk(i_clk), .i_nrst(i_nrst), .o_ep1_ready(r1), .o_ep2_ready(r2),
    .o_ep7_ready(r7));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic print_verdict();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic put(input logic [1:0] ep, input logic last, input logic [7:0] d);
    expq.push_back({ep, last, d});
  endtask

  task automatic hs_wait(input logic sel);
    int w;
    w = 0;
    @(negedge i_clk);
    while ((sel ? pix_ready : cmd_ready) !== 1'h1) begin
      @(negedge i_clk);
      w++;
      if (w > 5000) begin
        failures++;
        print_verdict();
      end
    end
    @(posedge i_clk);
  endtask

  task automatic send(input int n);
    @(posedge i_clk);
    for (int k = 0; k < n; k++) begin
      cmd_valid <= 1'h1;
      cmd_data <= pk[k];
      cmd_last <= (k == n - 1);
      hs_wait(1'h0);
    end
    cmd_valid <= 1'h0;
  endtask

  task automatic cmd3(input logic [7:0] c, input logic [7:0] lo, input logic [7:0] hi);
    pk[0] = c;
    pk[1] = lo;
    pk[2] = hi;
    send(3);
    @(negedge i_clk);
  endtask

  task automatic drain();
    int w;
    w = 0;
    while (expq.size() != 0) begin
      @(posedge i_clk);
      w++;
      if (w > 20000) begin
        failures++;
        print_verdict();
      end
    end
    repeat (8) @(posedge i_clk);
  endtask

  task automatic acquire(input logic speed);
    int a0;
    logic [10:0] m;
    hs <= speed;
    a0 = acq_n;
    m = speed ? 11'h0FF : 11'h01F;
    pk[0] = `SPC_CMD_ACQUIRE;
    send(1);
    ce_mix <= !speed;
    for (int i = 0; i < 2048; i++) begin
      seed = xs(seed);
      pix_valid <= 1'h1;
      pix_data <= seed[15:0];
      put(2'h2, 1'h0, seed[7:0]);
      put(2'h2, (i[10:0] & m) == m, seed[15:8]);
      hs_wait(1'h1);
    end
    pix_valid <= 1'h0;
    put(2'h2, 1'h1, 8'h69);
    drain();
    ce_mix <= 1'h0;
    `CHK(acq_n, a0 + 1)
    $display("acquire test done, high speed %0d", speed);
  endtask

  // ----------------------------------------
  // reply watcher and plug-in scan responder
  // ----------------------------------------
  // clock enable every other cycle while mixing
  always @(posedge i_clk) begin
    ce <= !ce_mix || !ce;
  end

  always @(negedge i_clk) begin
    if ((v1 & r1) | (v2 & r2) | (v7 & r7)) begin
      got_b = v1 ? {2'h1, l1, d1} : v2 ? {2'h2, l2, d2} : {2'h3, l7, d7};
      if (expq.size() == 0) begin
        failures++;
        $display("BAD %0t unexpected reply byte %h", $time, got_b);
      end else begin
        exp_b = expq.pop_front();
        `CHK(got_b, exp_b)
      end
    end
    if (acq === 1'h1) begin
      acq_n++;
    end
  end

  initial begin
    forever begin
      @(negedge i_clk);
      if (scan_req === 1'h1) begin
        @(posedge i_clk);
        scan_done <= 1'h1;
        @(posedge i_clk);
        scan_done <= 1'h0;
      end
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    int a1;
    repeat (5) @(posedge i_clk);
    i_nrst <= 1'h1;
    repeat (4) @(posedge i_clk);
    ss_raw <= 1'h1;
    cs_raw <= 1'h1;
    cmd3(`SPC_CMD_LAMP, 8'h01, 8'h00);
    `CHK({lamp, ss, cs}, 3'h7)
    cmd3(`SPC_CMD_LAMP, 8'h00, 8'h00);
    `CHK({lamp, ss, cs}, 3'h0)
    $display("lamp test done");
    for (int v = 0; v < 6; v++) begin
      cmd3(`SPC_CMD_TRIGGER, v[7:0], 8'h00);
      `CHK(trig, (v == 5) ? 3'h4 : v[2:0])
    end
    cmd3(`SPC_CMD_TRIGGER, 8'h02, 8'h00);
    cmd3(8'h07, 8'h01, 8'h00);
    pk[0] = `SPC_CMD_LAMP;
    pk[3] = 8'h00;
    send(4);
    drain();
    `CHK({lamp, trig}, 4'h2)
    $display("ignore test done");
    pk[0] = `SPC_CMD_CFG_WRITE;
    pk[1] = 8'h12;
    for (int k = 2; k < 18; k++) begin
      seed = xs(seed);
      pk[k] = seed[7:0];
    end
    pk[9] = 8'h00;
    send(18);
    put(2'h1, 1'h0, 8'h05);
    put(2'h1, 1'h0, 8'h12);
    for (int k = 2; k < 18; k++) begin
      put(2'h1, k == 17, pk[k]);
    end
    pk[0] = `SPC_CMD_CFG_QUERY;
    send(2);
    drain();
    pk[1] = 8'h14;
    send(2);
    drain();
    $display("config test done");
    put(2'h3, 1'h1, 8'h04);
    pk[0] = `SPC_CMD_PLUG_COUNT;
    send(1);
    drain();
    for (int k = 0; k < 6; k++) begin
      put(2'h3, 1'h0, plug_ids[8*k+:8]);
    end
    put(2'h3, 1'h1, 8'h00);
    pk[0] = `SPC_CMD_PLUG_IDS;
    send(1);
    drain();
    plug_ids <= 48'h000000550000;
    pk[0] = `SPC_CMD_PLUG_DETECT;
    send(1);
    repeat (8) @(posedge i_clk);
    put(2'h3, 1'h1, 8'h01);
    pk[0] = `SPC_CMD_PLUG_COUNT;
    send(1);
    drain();
    $display("plug-in test done");
    acquire(1'h1);
    acquire(1'h0);
    cmd3(`SPC_CMD_LAMP, 8'h01, 8'h00);
    cmd3(`SPC_CMD_SHUTDOWN, 8'h00, 8'h00);
    `CHK({sd_n, sup, lamp, ss, cs, trig}, 8'h00)
    a1 = acq_n;
    pk[0] = `SPC_CMD_ACQUIRE;
    send(1);
    drain();
    `CHK(acq_n, a1)
    cmd3(`SPC_CMD_SHUTDOWN, 8'h05, 8'h00);
    `CHK({sd_n, sup, lamp, trig}, 6'h3A)
    $display("shutdown test done");
    print_verdict();
  end
endmodule
